// ---- design/sbbx_core.v ----
// execute stage for shift, add-with-carry, bit and branch instructions
`timescale 1ns/10ps
`include "sbbx_defines.vh"
module sbbx_core #(
    parameter PCW = `SBBX_PC_W
) (
    input wire i_sys_clk,                     // clock, 25 MHz
    input wire i_rst_n,                       // synchronous reset, active low
    input wire i_valid,                       // instruction presented this cycle
    input wire [2:0] i_op,                    // operation select
    input wire [`SBBX_FADDR_W-1:0] i_faddr,   // file register address
    input wire i_dest,                        // 0 = W, 1 = file
    input wire [2:0] i_bit,                   // bit position
    input wire [`SBBX_OFS_W-1:0] i_ofs,       // signed branch literal
    output wire o_ready,                      // accepts an instruction
    output reg o_busy_nop,                    // second cycle running as nop
    output reg [PCW-1:0] o_pc,                // program counter
    output reg [7:0] o_w,                     // working register
    output reg o_carry,                       // carry flag
    output reg o_digit_carry_flag,            // digit carry flag
    output reg o_zero                         // zero flag
);
    localparam ST_IDLE = 3'b001;
    localparam ST_EXEC = 3'b010;
    localparam ST_FLUSH = 3'b100;

    reg [2:0] state;
    reg [2:0] op;
    reg [`SBBX_FADDR_W-1:0] faddr;
    reg dest;
    reg [2:0] bitpos;
    reg [`SBBX_OFS_W-1:0] ofs;
    wire [7:0] fdata;
    reg [7:0] next_res;
    reg next_we;
    reg [PCW-1:0] next_pc;
    reg next_flush;
    reg [8:0] sum;
    reg [4:0] nsum;

    // 9-bit signed literal stretched to counter width
    function [PCW-1:0] sext_ofs;
        input [`SBBX_OFS_W-1:0] k;
        begin
            sext_ofs = {{(PCW-`SBBX_OFS_W){k[`SBBX_OFS_SIGN]}}, k};
        end
    endfunction

    // one-hot mask for a bit position
    function [7:0] bit_mask;
        input [2:0] b;
        begin
            bit_mask = 8'h01 << b;
        end
    endfunction

    // one bank of 128 locations, addressed by 7 bits
    sbbx_file_ram #(
        .AW(`SBBX_FADDR_W),
        .DW(8)
    ) u_ram (
        .i_sys_clk(i_sys_clk),
        .i_raddr(i_faddr),
        .o_rdata(fdata),
        .i_we(next_we && state == ST_EXEC),
        .i_waddr(faddr),
        .i_wdata(next_res)
    );

    // the file read takes a cycle, so new work only enters from idle
    assign o_ready = (state == ST_IDLE);

    // compute result, write-back and counter change
    always @* begin
        next_res = fdata;
        next_we = 1'b0;
        next_pc = o_pc + {{(PCW-1){1'b0}}, 1'b1};
        next_flush = 1'b0;
        sum = {1'b0, o_w} + {1'b0, fdata} + {8'h00, o_carry};
        nsum = {1'b0, o_w[`SBBX_NIB-1:0]} + {1'b0, fdata[`SBBX_NIB-1:0]} + {4'h0, o_carry};
        case (op)
            `SBBX_OP_SHR: begin
                next_res = {fdata[`SBBX_MSB], fdata[`SBBX_MSB:1]};
                next_we = (dest == `SBBX_DEST_F);
            end
            `SBBX_OP_ADDC: begin
                next_res = sum[`SBBX_MSB:0];
                next_we = (dest == `SBBX_DEST_F);
            end
            `SBBX_OP_BCLR: begin
                next_res = fdata & ~bit_mask(bitpos);
                next_we = 1'b1;
            end
            `SBBX_OP_BSET: begin
                next_res = fdata | bit_mask(bitpos);
                next_we = 1'b1;
            end
            `SBBX_OP_TSKZ: begin
                next_flush = ~fdata[bitpos];
                next_pc = o_pc + (next_flush ? {{(PCW-2){1'b0}}, 2'b10}
                                             : {{(PCW-1){1'b0}}, 1'b1});
            end
            `SBBX_OP_BRLIT: begin
                next_pc = o_pc + {{(PCW-1){1'b0}}, 1'b1} + sext_ofs(ofs);
                next_flush = 1'b1;
            end
            `SBBX_OP_BRREG: begin
                next_pc = o_pc + {{(PCW-1){1'b0}}, 1'b1} + {{(PCW-8){1'b0}}, o_w};
                next_flush = 1'b1;
            end
            default: begin
                next_res = fdata;
            end
        endcase
    end

    // sequencer, working register and flags
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            op <= `SBBX_OP_NOP;
            faddr <= {`SBBX_FADDR_W{1'b0}};
            dest <= `SBBX_DEST_W;
            bitpos <= 3'h0;
            ofs <= {`SBBX_OFS_W{1'b0}};
            o_busy_nop <= 1'b0;
            o_pc <= `SBBX_PC_RST;
            o_w <= `SBBX_W_RST;
            o_carry <= 1'b0;
            o_digit_carry_flag <= 1'b0;
            o_zero <= 1'b0;
        end else begin
            o_busy_nop <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (i_valid) begin
                        op <= i_op;
                        faddr <= i_faddr;
                        dest <= i_dest;
                        bitpos <= i_bit;
                        ofs <= i_ofs;
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    o_pc <= next_pc;
                    if ((op == `SBBX_OP_SHR || op == `SBBX_OP_ADDC) &&
                        dest == `SBBX_DEST_W) begin
                        o_w <= next_res;
                    end
                    if (op == `SBBX_OP_SHR) begin
                        o_carry <= fdata[`SBBX_LSB];
                        o_zero <= (next_res == 8'h00);
                    end
                    if (op == `SBBX_OP_ADDC) begin
                        o_carry <= sum[`SBBX_CY];
                        o_digit_carry_flag <= nsum[`SBBX_NIB];
                        o_zero <= (sum[`SBBX_MSB:0] == 8'h00);
                    end
                    if (next_flush) begin
                        o_busy_nop <= 1'b1;
                        state <= ST_FLUSH;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_FLUSH: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- common/sbbx_defines.vh ----
// constants for the shift/bit/branch execute block
// Function
// - The arithmetic right shift moves every bit one place down, keeps bit 7 and puts bit 0 into carry.
// - For shift and add-with-carry, destination bit 0 sends the result to W and 1 writes it back to the file register.
// - Add-with-carry sums W, the file register and carry, then updates carry, digit carry and zero from that sum.
// - Bit clear forces the selected bit (0 to 7) of the file register to zero and leaves the flags alone.
// - Bit set forces the selected bit (0 to 7) of the file register to one and leaves the flags alone.
// - Test-skip-if-zero lets the next instruction run when the bit is one, else discards it as a one-cycle nop.
// - The literal branch adds a sign-extended 9-bit offset to the incremented counter and takes two cycles.
// - The register branch adds unsigned W to the incremented counter, takes two cycles and changes no flags.
// - Any branch or true skip costs a second cycle that executes as a nop.
`ifndef SBBX_DEFINES_VH
`define SBBX_DEFINES_VH
`define SBBX_OP_SHR 3'h0
`define SBBX_OP_ADDC 3'h1
`define SBBX_OP_BCLR 3'h2
`define SBBX_OP_BSET 3'h3
`define SBBX_OP_TSKZ 3'h4
`define SBBX_OP_BRLIT 3'h5
`define SBBX_OP_BRREG 3'h6
`define SBBX_OP_NOP 3'h7
`define SBBX_DEST_W 1'b0
`define SBBX_DEST_F 1'b1
`define SBBX_PC_W 15
`define SBBX_FADDR_W 7
`define SBBX_OFS_W 9
`define SBBX_OFS_SIGN 8
`define SBBX_MSB 7
`define SBBX_NIB 4
`define SBBX_LSB 0
`define SBBX_CY 8
`define SBBX_W_RST 8'h00
`define SBBX_PC_RST 15'h0000
`endif

// ---- design/sbbx_file_ram.v ----
// small data memory holding one bank of file registers
`timescale 1ns/10ps
module sbbx_file_ram #(
    parameter AW = 7,
    parameter DW = 8
) (
    input wire i_sys_clk,           // clock
    input wire [AW-1:0] i_raddr,    // read address
    output reg [DW-1:0] o_rdata,    // registered read data
    input wire i_we,                // write strobe
    input wire [AW-1:0] i_waddr,    // write address
    input wire [DW-1:0] i_wdata     // write data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // read data registered so the core sees it one cycle later
    always @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

// ---- verif/sbbx_core_assertions.sv ----
// concurrent checks on the execute block ports
`timescale 1ns/10ps
module sbbx_core_assertions #(parameter PCW = 15) (
    input wire i_sys_clk, input wire i_rst_n, input wire i_valid, input wire [2:0] i_op,
    input wire [6:0] i_faddr, input wire i_dest, input wire [2:0] i_bit, input wire [8:0] i_ofs,
    input wire o_ready, input wire o_busy_nop, input wire [PCW-1:0] o_pc, input wire [7:0] o_w,
    input wire o_carry, input wire o_digit_carry_flag, input wire o_zero
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // one-hot of the operation taken; its results are sampled two edges later
    wire [7:0] tk = {8{o_ready & i_valid}} & (8'h01 << i_op);
    wire [10:0] st = {o_w, o_carry, o_digit_carry_flag, o_zero};
    wire [PCW-1:0] ofs_x = {{(PCW-9){i_ofs[8]}}, i_ofs};
    // counter arithmetic wraps at the counter width, not at 32 bits
    function [PCW-1:0] adv(input [PCW-1:0] p, input [PCW-1:0] d);
        adv = p + d;
    endfunction
    a_shift_sign_kept: assert property (tk[0] && !i_dest |-> ##2 o_w[7] == o_w[6] && o_zero == (o_w == 8'h00)) else $error("shift result");
    a_file_dest_w: assert property (|tk[1:0] && i_dest |-> ##2 o_w == $past(o_w, 2)) else $error("w changed");
    a_addc_zero_pc: assert property (tk[1] && !i_dest |-> ##2 o_zero == (o_w == 8'h00) && o_pc == adv($past(o_pc, 2), 8'h01)) else $error("add result");
    a_clear_keeps_flags: assert property (tk[2] |-> ##2 st == $past(st, 2) && !o_busy_nop) else $error("clear flags");
    a_set_keeps_flags: assert property (tk[3] |-> ##2 st == $past(st, 2) && o_pc == adv($past(o_pc, 2), 8'h01)) else $error("set flags");
    a_skip_pc_step: assert property (tk[4] |-> ##2 o_pc == adv($past(o_pc, 2), o_busy_nop ? 8'h02 : 8'h01)) else $error("skip step");
    a_lit_branch_pc: assert property (tk[5] |-> ##2 o_busy_nop && o_pc == adv($past(o_pc, 2), 8'h01 + $past(ofs_x, 2))) else $error("literal branch");
    a_reg_branch_pc: assert property (tk[6] |-> ##2 o_busy_nop && st == $past(st, 2) && o_pc == adv($past(o_pc, 2), {7'h00, 8'h01} + {7'h00, $past(o_w, 2)})) else $error("w branch");
    a_nop_no_flush: assert property (tk[7] |=> !o_ready ##1 !o_busy_nop && o_ready) else $error("nop timing");
    a_flush_one_cycle: assert property (o_busy_nop |=> !o_busy_nop && o_ready) else $error("flush length");
endmodule
bind sbbx_core sbbx_core_assertions #(.PCW(PCW)) sbbx_core_assertions_inst (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_valid(i_valid), .i_op(i_op),
    .i_faddr(i_faddr), .i_dest(i_dest), .i_bit(i_bit), .i_ofs(i_ofs), .o_ready(o_ready),
    .o_busy_nop(o_busy_nop), .o_pc(o_pc), .o_w(o_w), .o_carry(o_carry),
    .o_digit_carry_flag(o_digit_carry_flag), .o_zero(o_zero));

// ---- verif/tb.sv ----
// self-checking bench for the execute block
`timescale 1ns/10ps
module tb;
    reg i_sys_clk = 0, i_rst_n = 0, i_valid = 0, i_dest = 0;
    reg [2:0] i_op = 0, i_bit = 0;
    reg [6:0] i_faddr = 0;
    reg [8:0] i_ofs = 0;
    wire o_ready, o_busy_nop, o_carry, o_digit_carry_flag, o_zero;
    wire [14:0] o_pc;
    wire [7:0] o_w;
    integer num_errors = 0, checks_done = 0, cycles = 0, nops = 0, i;
    reg [7:0] mem [0:127];
    reg [6:0] adr [0:3];
    reg [14:0] pc = 0;
    reg [7:0] w = 0;
    reg [31:0] r;
    reg c = 0, nib_c = 0, z = 0, prev_ready = 1;
    reg [26:0] exp_q [$];
    sbbx_core #(.PCW(15)) sbbx_core_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_valid(i_valid), .i_op(i_op), .i_faddr(i_faddr), .i_dest(i_dest), .i_bit(i_bit),
        .i_ofs(i_ofs), .o_ready(o_ready), .o_busy_nop(o_busy_nop), .o_pc(o_pc), .o_w(o_w),
        .o_carry(o_carry), .o_digit_carry_flag(o_digit_carry_flag), .o_zero(o_zero));
    initial forever #20 i_sys_clk = ~i_sys_clk;
    task check_state(input [26:0] got, input [26:0] want);
        checks_done = checks_done + 1;
        if (got !== want) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: state %h expected %h", $time, got, want);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // present one instruction, hold it until taken, then note the expected state
    task automatic issue(input [2:0] op, input [6:0] fa, input d, input [2:0] b,
        input [8:0] k, input junk);
        reg [7:0] f, q;
        reg [8:0] s;
        reg fl;
        begin
            @(posedge i_sys_clk);
            #1;
            {i_op, i_faddr, i_dest, i_bit, i_ofs, i_valid} = {op, fa, d, b, k, 1'b1};
            @(posedge i_sys_clk);
            while (o_ready !== 1'b1) @(posedge i_sys_clk);
            #1;
            f = mem[fa];
            q = f;
            fl = 0;
            pc = pc + 15'h1;
            case (op)
                3'h0: begin q = {f[7], f[7:1]}; c = f[0]; z = q == 8'h00; end
                3'h1: begin
                    s = w + f + c;
                    nib_c = ({1'b0, w[3:0]} + f[3:0] + c) > 5'h0f;
                    {c, q} = s;
                    z = q == 8'h00;
                end
                3'h2: mem[fa][b] = 1'b0;
                3'h3: mem[fa][b] = 1'b1;
                3'h4: if (!f[b]) {pc, fl} = {pc + 15'h1, 1'b1};
                3'h5: {pc, fl} = {pc + {{6{k[8]}}, k}, 1'b1};
                3'h6: {pc, fl} = {pc + {7'h00, w}, 1'b1};
                default: ;
            endcase
            if (op < 3'h2 && d) mem[fa] = q;
            else if (op < 3'h2) w = q;
            exp_q.push_back({pc, w, c, nib_c, z, fl});
            // a second request while busy must be ignored
            if (junk) i_op = 3'h6;
            else i_valid = 0;
        end
    endtask
    // watcher: each return of ready closes one instruction; also cuts a hang short
    always @(posedge i_sys_clk) begin
        cycles = cycles + 1;
        if (i_rst_n && o_ready && !prev_ready && exp_q.size() > 0) begin
            check_state({o_pc, o_w, o_carry, o_digit_carry_flag, o_zero, nops != 0}, exp_q.pop_front());
            nops = 0;
        end
        nops = nops + o_busy_nop;
        prev_ready = o_ready;
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: run hung", $time);
            wrap_up;
        end
    end
    initial begin
        void'($urandom(32'h6ac0));
        r = $urandom;
        {adr[0], adr[1], adr[2], adr[3]} = {7'h00, 7'h7f, r[6:0], r[6:0] ^ 7'h01};
        repeat (12) @(posedge i_sys_clk);
        #1 i_rst_n = 1;
        // build known bytes bit by bit; memory has no reset value
        for (i = 0; i < 32; i = i + 1) begin
            r = $urandom;
            issue({2'h1, r[0]}, adr[i / 8], r[1], i[2:0], 9'h000, r[2]);
        end
        $display("bit fill test done");
        issue(3'h5, 7'h00, 1'b0, 3'h0, 9'h100, 1'b1);
        issue(3'h5, 7'h00, 1'b0, 3'h0, 9'h0ff, 1'b0);
        for (i = 0; i < 70; i = i + 1) begin
            r = $urandom;
            issue(r[2:0], adr[r[4:3]], r[5], r[8:6], r[17:9], r[18]);
        end
        issue(3'h7, 7'h00, 1'b0, 3'h0, 9'h000, 1'b0);
        repeat (4) @(posedge i_sys_clk);
        $display("random mix test done, %0d notes left", exp_q.size());
        // a note never answered means an instruction went missing
        if (exp_q.size() != 0) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: unanswered notes", $time);
        end
        wrap_up;
    end
endmodule
